// [rtl/isf_status_flags.v]
// status flag logic of the two-wire bus interface
`include "isf_consts.vh"
`default_nettype none

module isf_status_flags
(
  // clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // control bits
  input  wire       iface_on,
  input  wire       irq_enable,
  input  wire       gen_call_enable,
  input  wire       ack_enable,
  // register port
  input  wire [7:0] reg_addr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       data_reg_rd,
  input  wire       data_reg_wr,
  input  wire       dma_done,
  // bus event pulses from the engine
  input  wire       bus_start_det,
  input  wire       bus_stop_det,
  input  wire       start_generated,
  input  wire       header_sent,
  input  wire       addr_ack_rx,
  input  wire       tx_ack_pulse_rx,
  input  wire       rx_ack_pulse_tx,
  input  wire       byte_is_tx,
  input  wire       no_ack_rx,
  input  wire       ack_pulse_fell,
  input  wire       addr_match_own,
  input  wire       addr_match_gen,
  input  wire       arb_lost,
  input  wire       in_byte,
  input  wire       on_ack_pulse,
  // outputs
  output reg        scl_hold,
  output reg        irq
);

  reg       event_flag_q;
  reg       header_sent_flag;
  reg       direction_flag;
  reg       busy_flag;
  reg       byte_done_flag;
  reg       addr_match_flag;
  reg       master_flag;
  reg       start_sent_flag;
  reg       addr_acked_flag;
  reg       ack_fail_flag;
  reg       stop_seen_flag;
  reg       arb_lost_flag;
  reg       bus_error_flag;
  reg       gen_call_match_flag;
  reg       one_read_armed;
  reg       ack_fell_seen;
  reg       irq_block;
  reg       next_scl_hold;
  reg       next_irq;

  wire rd_one = reg_rd && (reg_addr == `ISF_OFS_STATUS_ONE);
  wire rd_two = reg_rd && (reg_addr == `ISF_OFS_STATUS_TWO);

  wire misplaced_start = bus_start_det && in_byte;
  wire misplaced_stop  = bus_stop_det && in_byte;
  wire set_bus_error_flag  = misplaced_start || misplaced_stop;
  // the engine only reports a loss while it drives as master
  wire set_arb_lost_flag  = arb_lost || misplaced_start;
  wire set_af    = no_ack_rx || (misplaced_stop && on_ack_pulse);
  wire set_stop_seen_flag = bus_stop_det && !master_flag && !in_byte;
  wire set_btf   = (byte_is_tx && tx_ack_pulse_rx) || (!byte_is_tx && ack_enable && rx_ack_pulse_tx);
  wire set_addr_match_flag  = addr_match_own || (addr_match_gen && gen_call_enable);
  wire any_set   = set_btf || set_addr_match_flag || start_generated || header_sent || set_af || set_stop_seen_flag ||
                   set_arb_lost_flag || set_bus_error_flag || (addr_ack_rx && master_flag);
  // a start only counts on a free bus
  wire set_sb    = start_generated && !busy_flag;
  // an address acknowledge only counts as master
  wire set_addr_acked_flag = addr_ack_rx && master_flag;
  wire set_gen_call_match_flag  = addr_match_gen && gen_call_enable;

  // clear sequences: a status one read arms, the following data access fires
  wire seq_any_access = one_read_armed && (data_reg_rd || data_reg_wr);
  wire seq_data_write = one_read_armed && data_reg_wr;
  wire clr_byte_done  = seq_any_access || dma_done;
  wire clr_direction  = clr_byte_done || bus_stop_det || set_arb_lost_flag;
  wire clr_header     = seq_data_write || set_stop_seen_flag;
  wire clr_start_sent = seq_data_write;
  wire clr_addr_acked = seq_data_write;
  wire clr_master     = bus_stop_det || set_arb_lost_flag;
  wire clr_gen_call   = bus_stop_det;
  // a stale fall from an earlier byte must not allow the clear
  wire clr_ack_fail   = rd_two && ack_fell_seen;

  wire [7:0] one_view = {event_flag_q, header_sent_flag, direction_flag, busy_flag,
                         byte_done_flag, addr_match_flag, master_flag, start_sent_flag};
  wire [7:0] two_view = {2'b00, addr_acked_flag, ack_fail_flag, stop_seen_flag,
                         arb_lost_flag, bus_error_flag, gen_call_match_flag};

  // busy follows bus even when disabled
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      busy_flag <= 1'b0;
    else if (bus_start_det)
      busy_flag <= 1'b1;
    else if (bus_stop_det)
      busy_flag <= 1'b0;
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      header_sent_flag    <= 1'b0;
      direction_flag      <= 1'b0;
      byte_done_flag      <= 1'b0;
      addr_match_flag     <= 1'b0;
      master_flag         <= 1'b0;
      start_sent_flag     <= 1'b0;
      addr_acked_flag     <= 1'b0;
      ack_fail_flag       <= 1'b0;
      stop_seen_flag      <= 1'b0;
      arb_lost_flag       <= 1'b0;
      bus_error_flag      <= 1'b0;
      gen_call_match_flag <= 1'b0;
    end
    else if (!iface_on)
    begin
      header_sent_flag    <= 1'b0;
      direction_flag      <= 1'b0;
      byte_done_flag      <= 1'b0;
      addr_match_flag     <= 1'b0;
      master_flag         <= 1'b0;
      start_sent_flag     <= 1'b0;
      addr_acked_flag     <= 1'b0;
      ack_fail_flag       <= 1'b0;
      stop_seen_flag      <= 1'b0;
      arb_lost_flag       <= 1'b0;
      bus_error_flag      <= 1'b0;
      gen_call_match_flag <= 1'b0;
    end
    else
    begin
      if (set_btf)
        byte_done_flag <= 1'b1;
      else if (clr_byte_done)
        byte_done_flag <= 1'b0;

      if (set_btf)
        direction_flag <= byte_is_tx;
      else if (clr_direction)
        direction_flag <= 1'b0;

      if (header_sent)
        header_sent_flag <= 1'b1;
      else if (clr_header)
        header_sent_flag <= 1'b0;

      if (set_sb)
        start_sent_flag <= 1'b1;
      else if (clr_start_sent)
        start_sent_flag <= 1'b0;

      if (start_generated)
        master_flag <= 1'b1;
      else if (clr_master)
        master_flag <= 1'b0;

      if (set_addr_match_flag)
        addr_match_flag <= 1'b1;
      else if (rd_one)
        addr_match_flag <= 1'b0;

      if (set_addr_acked_flag)
        addr_acked_flag <= 1'b1;
      else if (clr_addr_acked)
        addr_acked_flag <= 1'b0;

      // ack fail clears only on read after pulse falls
      if (set_af)
        ack_fail_flag <= 1'b1;
      else if (clr_ack_fail)
        ack_fail_flag <= 1'b0;

      if (set_stop_seen_flag)
        stop_seen_flag <= 1'b1;
      else if (rd_two)
        stop_seen_flag <= 1'b0;

      if (set_arb_lost_flag)
        arb_lost_flag <= 1'b1;
      else if (rd_two)
        arb_lost_flag <= 1'b0;

      if (set_bus_error_flag)
        bus_error_flag <= 1'b1;
      else if (rd_two)
        bus_error_flag <= 1'b0;

      if (set_gen_call_match_flag)
        gen_call_match_flag <= 1'b1;
      else if (clr_gen_call)
        gen_call_match_flag <= 1'b0;
    end
  end

  // event flag is the union of its causes, already cleared on disable
  always @*
  begin
    event_flag_q = byte_done_flag | addr_match_flag | start_sent_flag | header_sent_flag |
                   addr_acked_flag | ack_fail_flag | stop_seen_flag | arb_lost_flag |
                   bus_error_flag;
  end

  // sequence bookkeeping: arm, acknowledge fall and interrupt suppression
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      one_read_armed <= 1'b0;
      ack_fell_seen  <= 1'b0;
      irq_block      <= 1'b0;
    end
    else if (!iface_on)
    begin
      one_read_armed <= 1'b0;
      ack_fell_seen  <= 1'b0;
      irq_block      <= 1'b0;
    end
    else
    begin
      // a status two read leaves the arm in place; any data access consumes it
      if (rd_one)
        one_read_armed <= 1'b1;
      else if (data_reg_rd || data_reg_wr)
        one_read_armed <= 1'b0;

      // a new failure restarts the wait for the falling acknowledge clock
      if (ack_pulse_fell)
        ack_fell_seen <= 1'b1;
      else if (set_af)
        ack_fell_seen <= 1'b0;

      // an event landing on a read gives no interrupt
      if (reg_rd && any_set)
        irq_block <= 1'b1;
      else if (any_set)
        irq_block <= 1'b0;
    end
  end

  // read path; data shows the flags before this cycle's clears
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= `ISF_RST_STATUS;
    else if (rd_one)
      reg_rdata <= one_view;
    else if (rd_two)
      reg_rdata <= two_view;
    else
      reg_rdata <= `ISF_RST_STATUS;
  end

  always @*
  begin
    next_scl_hold = iface_on && (byte_done_flag || addr_match_flag || start_sent_flag ||
                                 addr_acked_flag || header_sent_flag);
  end

  // interrupt gated by enable and read-clear exception
  always @*
  begin
    next_irq = iface_on && irq_enable && event_flag_q && !irq_block;
  end

  // registered so the pin never glitches while several flags change at once
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      scl_hold <= 1'b0;
    else
      scl_hold <= next_scl_hold;
  end

  // registered for the same reason; costs one cycle of latency
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= next_irq;
  end

endmodule // isf_status_flags
`default_nettype wire

// [rtl/isf_consts.vh]
// constants for the two-wire bus status flag block
`ifndef ISF_CONSTS_VH
`define ISF_CONSTS_VH
`define ISF_OFS_STATUS_ONE 8'hf1
`define ISF_OFS_STATUS_TWO 8'hf2
`define ISF_RST_STATUS     8'h00
`define ISF_B_EVENT        7
`define ISF_B_HEADER       6
`define ISF_B_DIR          5
`define ISF_B_BUSY         4
`define ISF_B_BYTE_DONE    3
`define ISF_B_ADDR_MATCH   2
`define ISF_B_MASTER       1
`define ISF_B_START_SENT   0
`define ISF_B_ADDR_ACKED   5
`define ISF_B_ACK_FAIL     4
`define ISF_B_STOP_SEEN    3
`define ISF_B_ARB_LOST     2
`define ISF_B_BUS_ERROR    1
`define ISF_B_GEN_CALL     0
`endif

// [bench/isf_bus_model.sv]
// remote bus party: turns a bench event code into one-cycle event pulses
`default_nettype none
module isf_bus_model
(
  // event code, zero for none
  input  wire logic [3:0]  ev,
  // one-hot pulses, bit n for code n+1
  output var  logic [11:0] pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  // the bench steps codes at the falling edge, so every pulse spans one full cycle
  always_comb pulse = (ev == 4'h0) ? 12'h000 : (12'h001 << (ev - 4'h1));
endmodule // isf_bus_model
`default_nettype wire

// [bench/isf_status_properties.sv]
// port checks for the status flag block
`include "isf_consts.vh"
`default_nettype none
module isf_status_props
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // watched inputs
  input wire logic       iface_on,
  input wire logic       irq_enable,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic       bus_start_det,
  input wire logic       bus_stop_det,
  input wire logic       tx_ack_pulse_rx,
  input wire logic       byte_is_tx,
  input wire logic       no_ack_rx,
  input wire logic       arb_lost,
  input wire logic       in_byte,
  // watched outputs
  input wire logic [7:0] reg_rdata,
  input wire logic       scl_hold,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire rd1 = reg_rd && reg_addr == `ISF_OFS_STATUS_ONE;
  wire rd2 = reg_rd && reg_addr == `ISF_OFS_STATUS_TWO;
  rsv_zero_a: assert property (rd2 |=> reg_rdata[7:6] == 2'b00)
    else $error("status two top bits set");
  off_quiet_a: assert property (!iface_on [*3] |-> !scl_hold && !irq)
    else $error("disabled block holds clock or irq");
  irq_gate_a: assert property (!irq_enable [*3] |-> !irq)
    else $error("irq while interrupts off");
  byte_hold_a:
    assert property (tx_ack_pulse_rx && byte_is_tx && iface_on && !reg_rd ##1 iface_on
      |-> ##1 scl_hold && (irq || !$past(irq_enable))) else $error("no hold after byte");
  busy_set_a:
    assert property (bus_start_det && !bus_stop_det ##1 !bus_stop_det ##1 rd1 |=> reg_rdata[`ISF_B_BUSY])
    else $error("busy not set by start");
  ack_fail_a:
    assert property (no_ack_rx && iface_on ##1 !reg_rd && iface_on ##1 rd2 && iface_on
      |=> reg_rdata[`ISF_B_ACK_FAIL]) else $error("ack failure not flagged");
  arb_lost_a:
    assert property (arb_lost && iface_on ##1 !reg_rd && iface_on ##1 rd2 && iface_on
      |=> reg_rdata[`ISF_B_ARB_LOST]) else $error("arbitration loss not flagged");
  misplaced_a:
    assert property (bus_start_det && in_byte && iface_on ##1 !reg_rd && iface_on ##1 rd2 && iface_on
      |=> reg_rdata[2:1] == 2'b11) else $error("misplaced start not flagged");
endmodule // isf_status_props
`default_nettype wire

// [bench/isf_status_flags_tb_top.sv]
// self-checking bench for the status flag block
`include "isf_consts.vh"
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module isf_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst_n, iface_on, irq_enable, gen_call_enable, ack_enable, reg_rd;
  logic        data_reg_rd, data_reg_wr, dma_done, byte_is_tx, in_byte, on_ack_pulse;
  logic [7:0]  reg_addr;
  logic [3:0]  ev;
  wire  [7:0]  reg_rdata;
  wire  [11:0] p;
  wire         scl_hold, irq;
  int          n_errors = 0;
  int          n_checks = 0;
  isf_bus_model i_isf_bus_model (.ev(ev), .pulse(p));
  isf_status_flags i_isf_status_flags
  (
    .mclk, .rst_n, .iface_on, .irq_enable, .gen_call_enable, .ack_enable, .reg_addr, .reg_rd,
    .reg_rdata, .data_reg_rd, .data_reg_wr, .dma_done, .bus_start_det(p[0]), .bus_stop_det(p[1]),
    .start_generated(p[2]), .header_sent(p[3]), .addr_ack_rx(p[4]), .tx_ack_pulse_rx(p[5]),
    .rx_ack_pulse_tx(p[6]), .byte_is_tx, .no_ack_rx(p[7]), .ack_pulse_fell(p[8]),
    .addr_match_own(p[9]), .addr_match_gen(p[10]), .arb_lost(p[11]), .in_byte, .on_ack_pulse,
    .scl_hold, .irq
  );
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic pulse(input logic [3:0] c);
    @(negedge mclk);
    ev = c;
    @(negedge mclk);
    ev = 4'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    `CHK("reg_rdata", e, reg_rdata)
  endtask
  task automatic rd1(input logic [7:0] e);
    rd(`ISF_OFS_STATUS_ONE, e);
  endtask
  task automatic rd2(input logic [7:0] e);
    rd(`ISF_OFS_STATUS_TWO, e);
  endtask
  task automatic dacc(input logic wr);
    @(negedge mclk);
    data_reg_wr = wr;
    data_reg_rd = !wr;
    @(negedge mclk);
    data_reg_wr = 1'b0;
    data_reg_rd = 1'b0;
  endtask
  task automatic hold(input logic s, input logic i);
    @(negedge mclk);
    `CHK("scl_hold", s, scl_hold)
    `CHK("irq", i, irq)
  endtask
  initial
  begin
    {iface_on, irq_enable, gen_call_enable, ack_enable, reg_rd, data_reg_rd, data_reg_wr} = 7'h00;
    {dma_done, byte_is_tx, in_byte, on_ack_pulse, reg_addr, ev, rst_n} = 17'h00000;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    rd1(8'h00);
    rd2(8'h00);
    rd(8'hf3, 8'h00);
    // codes: 1 start, 2 stop, 3 start made, 4 header, 5 addr ack, 6 tx ack, 7 rx ack,
    // 8 no ack, 9 ack fell, 10 own match, 11 general match, 12 arbitration lost
    pulse(4'h1);
    rd1(8'h10);
    pulse(4'h6);
    rd1(8'h10);
    hold(1'b0, 1'b0);
    iface_on = 1'b1;
    irq_enable = 1'b1;
    pulse(4'h2);
    rd1(8'h80);
    rd2(8'h08);
    byte_is_tx = 1'b1;
    pulse(4'h6);
    hold(1'b1, 1'b1);
    rd1(8'ha8);
    dacc(1'b1);
    rd1(8'h00);
    hold(1'b0, 1'b0);
    irq_enable = 1'b0;
    pulse(4'h6);
    hold(1'b1, 1'b0);
    @(negedge mclk);
    dma_done = 1'b1;
    @(negedge mclk);
    dma_done = 1'b0;
    rd1(8'h00);
    {byte_is_tx, ack_enable} = 2'b01;
    pulse(4'h7);
    rd1(8'h88);
    dacc(1'b0);
    rd1(8'h00);
    pulse(4'h3);
    pulse(4'h5);
    rd2(8'h20);
    hold(1'b1, 1'b0);
    rd1(8'h83);
    dacc(1'b1);
    rd1(8'h02);
    pulse(4'h4);
    rd1(8'hc2);
    dacc(1'b1);
    rd1(8'h02);
    pulse(4'hc);
    rd2(8'h04);
    rd1(8'h00);
    pulse(4'h8);
    rd2(8'h10);
    rd2(8'h10);
    pulse(4'h9);
    rd2(8'h10);
    rd2(8'h00);
    pulse(4'ha);
    rd1(8'h84);
    rd1(8'h00);
    // general call address taken only while its enable is set
    gen_call_enable = 1'b1;
    pulse(4'hb);
    rd2(8'h01);
    rd1(8'h84);
    pulse(4'h2);
    rd2(8'h08);
    in_byte = 1'b1;
    pulse(4'h1);
    rd2(8'h06);
    on_ack_pulse = 1'b1;
    pulse(4'h2);
    rd2(8'h12);
    pulse(4'h9);
    rd2(8'h10);
    pulse(4'ha);
    iface_on = 1'b0;
    rd1(8'h00);
    print_verdict();
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end
endmodule // isf_status_flags_tb_top
bind isf_status_flags isf_status_props i_isf_status_props (.mclk, .rst_n, .iface_on, .irq_enable,
  .reg_addr, .reg_rd, .bus_start_det, .bus_stop_det, .tx_ack_pulse_rx, .byte_is_tx, .no_ack_rx,
  .arb_lost, .in_byte, .reg_rdata, .scl_hold, .irq);
`default_nettype wire
